/* sim/bism_host_model.sv */
// Host interrupt controller model that samples the four shared lines.
`timescale 1ns/1ps
`default_nettype none
module bism_host_model
   import bism_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       inta_n,
   input  wire logic       intb_n,
   input  wire logic       interrupt_clear_n,
   input  wire logic       intd_n,
   output logic      [3:0] seen
);
   always_ff @(posedge pclk) begin
      seen <= ~{intd_n, interrupt_clear_n, intb_n, inta_n};
   end
endmodule
`default_nettype wire

/* sim/bism_properties.sv */
// Concurrent checks on the interrupt status and routing block.
`timescale 1ns/1ps
`default_nettype none
`include "bism_defs.svh"
module bism_properties
   import bism_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        soft_reset,
   input wire logic        local_reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [31:0] source_event,
   input wire logic        inta_n,
   input wire logic        intb_n,
   input wire logic        interrupt_clear_n,
   input wire logic        intd_n,
   input wire logic        irq
);
   logic [31:0] oe_reg;
   logic [31:0] rt_reg;
   logic        rd;
   logic [3:0]  ln;
   assign rd = psel && !penable && !pwrite;
   assign ln = {intd_n, interrupt_clear_n, intb_n, inta_n};
   // Shadow copies of the output enable and first route register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_reg <= '0;
         rt_reg <= '0;
      end else if (soft_reset || local_reset) begin
         oe_reg <= '0;
         rt_reg <= '0;
      end else if (psel && penable && pwrite) begin
         if (paddr == 12'h44c) oe_reg <= pwdata & `BISM_SRC_MASK;
         if (paddr == 12'h458) rt_reg <= pwdata & `BISM_ROUTE_ONE_MASK;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pend_reserved: assert property (rd && paddr == 12'h450 |=> (prdata & ~`BISM_SRC_MASK) == 0)
      else $error("pending reserved bits set");
   a_clear_reads_zero: assert property (rd && paddr == 12'h454 |=> prdata == 0)
      else $error("clear register read not zero");
   a_route_readback: assert property (rd && paddr == 12'h458 |=> prdata == $past(rt_reg))
      else $error("route one read back wrong");
   a_oe_readback: assert property (rd && paddr == 12'h44c |=> prdata == $past(oe_reg))
      else $error("output enable read back wrong");
   a_reset_quiet: assert property (soft_reset || local_reset |=> ln == 4'hf && !irq)
      else $error("outputs active after reset");
   a_mapped_ok: assert property (psel && penable && paddr inside {12'h450, 12'h454, 12'h458} |-> !pslverr)
      else $error("mapped register refused");
   a_event_line: assert property ((source_event[24] && !soft_reset && !local_reset) ##1
      (oe_reg[24] && !soft_reset && !local_reset) |=> !ln[$past(rt_reg[17:16])])
      else $error("routed line not asserted");
   a_oe_gate: assert property (oe_reg == 0 && $past(oe_reg) == 0 |-> ln == 4'hf)
      else $error("line asserted with outputs disabled");
endmodule
bind bism_irq_map bism_properties u_props (.pclk, .presetn, .soft_reset, .local_reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .source_event, .inta_n, .intb_n,
   .interrupt_clear_n, .intd_n, .irq);
`default_nettype wire

/* sim/bridge_interrupt_status_clear_map_bench.sv */
// Self-checking bench for the interrupt status and routing block.
`timescale 1ns/1ps
`default_nettype none
module bridge_interrupt_status_clear_map_bench
   import bism_pkg::*;
;
   logic        pclk = 0, presetn = 0, soft_reset = 0, local_reset = 0;
   logic        psel = 0, penable = 0, pwrite = 0, pslverr, pready, irq, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, source_event = 32'h0, prdata, q;
   logic [7:1]  request_level_n = 7'h7f;
   logic        inta_n, intb_n, interrupt_clear_n, intd_n;
   logic [3:0]  seen;
   int          n_mismatch = 0, n_compared = 0;
   always #10 pclk = ~pclk;
   bism_irq_map DUT (.pclk, .presetn, .soft_reset, .local_reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .source_event, .request_level_n,
      .inta_n, .intb_n, .interrupt_clear_n, .intd_n, .irq);
   bism_host_model host (.pclk, .inta_n, .intb_n, .interrupt_clear_n, .intd_n, .seen);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic ev(input logic [31:0] m);
      source_event <= m;
      @(posedge pclk);
      source_event <= 32'h0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic t_reset;
      rd(12'h450, 32'h0);
      chk(err, 32'h0);
      rd(12'h454, 32'h0);
      rd(12'h458, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      chk(err, 32'h1);
      $display("reset test done");
   endtask
   task automatic t_bits;
      ev(32'hffffffff);
      rd(12'h450, 32'h03ff3f00);
      apb(1'b1, 12'h450, 32'h0);
      apb(1'b1, 12'h454, 32'h000000ff);
      rd(12'h450, 32'h03ff3f00);
      apb(1'b1, 12'h454, 32'hffffffff);
      rd(12'h450, 32'h0);
      $display("bits test done");
   endtask
   task automatic t_route;
      apb(1'b1, 12'h44c, 32'h01000000);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, 12'h458, 32'(r) << 16);
         ev(32'h01000000);
         chk(seen, 32'h1 << r);
         apb(1'b1, 12'h454, 32'h01000000);
         rd(12'h450, 32'h0);
      end
      apb(1'b1, 12'h44c, 32'h0);
      ev(32'h00010000);
      chk(seen, 32'h0);
      // The event stands only at the access edge of the clear, so only set-wins keeps it.
      fork
         apb(1'b1, 12'h454, 32'h00010000);
         begin
            @(posedge pclk);
            source_event <= 32'h00010000;
            @(posedge pclk);
            source_event <= 32'h0;
         end
      join
      rd(12'h450, 32'h00010000);
      $display("route test done");
   endtask
   task automatic t_level;
      apb(1'b1, 12'h448, 32'h000000fe);
      request_level_n <= 7'h5b;
      repeat (4) @(posedge pclk);
      rd(12'h450, 32'h00010048);
      apb(1'b1, 12'h460, 32'h00000108);
      chk(irq, 32'h1);
      apb(1'b1, 12'h460, 32'h0);
      chk(irq, 32'h0);
      request_level_n <= 7'h7f;
      ev(32'h00000100);
      apb(1'b1, 12'h460, 32'h00000108);
      chk(irq, 32'h1);
      apb(1'b1, 12'h454, 32'h00000100);
      chk(irq, 32'h0);
      $display("level test done");
   endtask
   task automatic t_route2;
      apb(1'b1, 12'h45c, 32'hffffffff);
      rd(12'h45c, 32'h0ffffffc);
      apb(1'b1, 12'h45c, 32'h08000004);
      apb(1'b1, 12'h44c, 32'h00002002);
      ev(32'h00002000);
      chk(seen, 32'h4);
      apb(1'b1, 12'h454, 32'h00002000);
      request_level_n <= 7'h7e;
      repeat (6) @(posedge pclk);
      chk(seen, 32'h2);
      request_level_n <= 7'h7f;
      apb(1'b1, 12'h44c, 32'h0);
      $display("route two test done");
   endtask
   task automatic t_sreset;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 12'h458, 32'hffffffff);
         rd(12'h458, 32'h000fffff);
         soft_reset <= (k == 0);
         local_reset <= (k == 1);
         @(posedge pclk);
         soft_reset <= 1'b0;
         local_reset <= 1'b0;
         rd(12'h458, 32'h0);
         rd(12'h450, 32'h0);
      end
      $display("soft reset test done");
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_bits;
      t_route;
      t_level;
      t_route2;
      t_sreset;
      end_of_test;
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test;
   end
endmodule
`default_nettype wire

/* src/bism_defs.svh */
// Register offsets, field positions and reset values of the interrupt status and routing block.
`ifndef BISM_DEFS_SVH
`define BISM_DEFS_SVH

`define BISM_OFF_INPUT_EN     12'h448
`define BISM_OFF_OUTPUT_EN    12'h44c
`define BISM_OFF_PENDING      12'h450
`define BISM_OFF_CLEAR        12'h454
`define BISM_OFF_ROUTE_ONE    12'h458
`define BISM_OFF_ROUTE_TWO    12'h45c
`define BISM_OFF_IRQ_ENABLE   12'h460

`define BISM_LATCH_MASK       32'h03ff3f00
`define BISM_LEVEL_MASK       32'h000000fe
`define BISM_SRC_MASK         32'h03ff3ffe
`define BISM_ROUTE_ONE_MASK   32'h000fffff
`define BISM_ROUTE_TWO_MASK   32'h0ffffffc
`define BISM_RESET_VALUE      32'h00000000

`define BISM_POS_XFER1        25
`define BISM_POS_XFER0        24
`define BISM_POS_MBOX0        16
`define BISM_POS_ACFAIL       8
`define BISM_POS_LEVEL1       1

`endif

/* src/bism_irq_map.sv */
// Interrupt pending, clear, enable and routing logic with an APB register port.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bism_defs.svh"

module bism_irq_map
   import bism_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        soft_reset,
   input  wire logic        local_reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] source_event,
   input  wire logic [7:1]  request_level_n,
   output logic             inta_n,
   output logic             intb_n,
   output logic             interrupt_clear_n,
   output logic             intd_n,
   output logic             irq
);

   logic [31:0] pending_reg;
   logic [31:0] input_en_reg;
   logic [31:0] output_en_reg;
   logic [31:0] route_one_reg;
   logic [31:0] route_two_reg;
   logic [31:0] irq_enable_reg;
   logic [7:1]  level_meta_reg;
   logic [7:1]  level_sync_reg;
   logic [3:0]  line_reg;
   logic [31:0] prdata_next;
   logic [31:0] clear_vec;
   logic [31:0] level_vec;
   logic [3:0]  line_next;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic        local_rst;
   bism_route_t route_sel [31:0];

   // Route field of every source, named by what it serves.
   bism_route_t xfer_engine1_route;
   bism_route_t xfer_engine0_route;
   bism_route_t loc_monitor3_route;
   bism_route_t loc_monitor2_route;
   bism_route_t loc_monitor1_route;
   bism_route_t loc_monitor0_route;
   bism_route_t mailbox3_route;
   bism_route_t mailbox2_route;
   bism_route_t mailbox1_route;
   bism_route_t mailbox0_route;
   bism_route_t host_bus_error_route;
   bism_route_t backplane_error_route;
   bism_route_t request_edge_route;
   bism_route_t acknowledge_route;
   bism_route_t system_fail_route;
   bism_route_t ac_fail_route;
   bism_route_t request_level7_route;
   bism_route_t request_level6_route;
   bism_route_t request_level5_route;
   bism_route_t request_level4_route;
   bism_route_t request_level3_route;
   bism_route_t request_level2_route;
   bism_route_t request_level1_route;

   // Zero wait states: every access ends at its first access edge.
   assign local_rst = soft_reset | local_reset;
   assign wr_en     = psel & penable & pwrite;
   assign rd_en     = psel & ~penable & ~pwrite;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~addr_ok;

   // Unmapped offsets answer with an error, and writes to them are dropped.
   always_comb begin
      case (paddr)
         `BISM_OFF_INPUT_EN, `BISM_OFF_OUTPUT_EN, `BISM_OFF_PENDING, `BISM_OFF_CLEAR,
         `BISM_OFF_ROUTE_ONE, `BISM_OFF_ROUTE_TWO, `BISM_OFF_IRQ_ENABLE: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // The request level pins come from the backplane, so they are synchronised first.
   // Only the second stage is read, so a metastable first stage never reaches logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_meta_reg <= 7'h00;
         level_sync_reg <= 7'h00;
      end else begin
         level_meta_reg <= ~request_level_n;
         level_sync_reg <= level_meta_reg;
      end
   end

   // Level sources show the live line state while input-enabled.
   assign level_vec = {24'h000000, level_sync_reg, 1'b0} & input_en_reg & `BISM_LEVEL_MASK;

   // Only latched positions can be cleared; the level bits have no clear.
   assign clear_vec = (wr_en && paddr == `BISM_OFF_CLEAR) ? (pwdata & `BISM_LATCH_MASK)
                                                          : 32'h00000000;

   // Latched sources set on their event, a clear never beats a same-cycle set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_reg <= `BISM_RESET_VALUE;
      end else if (local_rst) begin
         pending_reg <= `BISM_RESET_VALUE;
      end else begin
         pending_reg <= (((pending_reg & ~clear_vec) | source_event) & `BISM_LATCH_MASK)
                        | level_vec;
      end
   end

   // Every control register has a process of its own, and each one clears on any of the
   // three resets, so software always finds them zero after a reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_en_reg <= `BISM_RESET_VALUE;
      end else if (local_rst) begin
         input_en_reg <= `BISM_RESET_VALUE;
      end else if (wr_en && paddr == `BISM_OFF_INPUT_EN) begin
         input_en_reg <= pwdata & `BISM_LEVEL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_en_reg <= `BISM_RESET_VALUE;
      end else if (local_rst) begin
         output_en_reg <= `BISM_RESET_VALUE;
      end else if (wr_en && paddr == `BISM_OFF_OUTPUT_EN) begin
         output_en_reg <= pwdata & `BISM_SRC_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_one_reg <= `BISM_RESET_VALUE;
      end else if (local_rst) begin
         route_one_reg <= `BISM_RESET_VALUE;
      end else if (wr_en && paddr == `BISM_OFF_ROUTE_ONE) begin
         route_one_reg <= pwdata & `BISM_ROUTE_ONE_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_two_reg <= `BISM_RESET_VALUE;
      end else if (local_rst) begin
         route_two_reg <= `BISM_RESET_VALUE;
      end else if (wr_en && paddr == `BISM_OFF_ROUTE_TWO) begin
         route_two_reg <= pwdata & `BISM_ROUTE_TWO_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_reg <= `BISM_RESET_VALUE;
      end else if (local_rst) begin
         irq_enable_reg <= `BISM_RESET_VALUE;
      end else if (wr_en && paddr == `BISM_OFF_IRQ_ENABLE) begin
         irq_enable_reg <= pwdata & `BISM_SRC_MASK;
      end
   end

   // Route one fields for the engines, monitors and mailboxes.
   assign xfer_engine1_route    = route_one_reg[19:18];
   assign xfer_engine0_route    = route_one_reg[17:16];
   assign loc_monitor3_route    = route_one_reg[15:14];
   assign loc_monitor2_route    = route_one_reg[13:12];
   assign loc_monitor1_route    = route_one_reg[11:10];
   assign loc_monitor0_route    = route_one_reg[9:8];
   assign mailbox3_route        = route_one_reg[7:6];
   assign mailbox2_route        = route_one_reg[5:4];
   assign mailbox1_route        = route_one_reg[3:2];
   assign mailbox0_route        = route_one_reg[1:0];

   // Route two fields for the error, edge, acknowledge, fail and level sources.
   assign host_bus_error_route  = route_two_reg[27:26];
   assign backplane_error_route = route_two_reg[25:24];
   assign request_edge_route    = route_two_reg[23:22];
   assign acknowledge_route     = route_two_reg[21:20];
   assign system_fail_route     = route_two_reg[19:18];
   assign ac_fail_route         = route_two_reg[17:16];
   assign request_level7_route  = route_two_reg[15:14];
   assign request_level6_route  = route_two_reg[13:12];
   assign request_level5_route  = route_two_reg[11:10];
   assign request_level4_route  = route_two_reg[9:8];
   assign request_level3_route  = route_two_reg[7:6];
   assign request_level2_route  = route_two_reg[5:4];
   assign request_level1_route  = route_two_reg[3:2];

   // Gather each source's route field by its status position.
   always_comb begin
      // Positions without a source keep route zero; they are never pending.
      for (int i = 0; i < 32; i++) begin
         route_sel[i] = 2'b00;
      end
      route_sel[`BISM_POS_XFER1]      = xfer_engine1_route;
      route_sel[`BISM_POS_XFER0]      = xfer_engine0_route;
      route_sel[`BISM_POS_MBOX0 + 7]  = loc_monitor3_route;
      route_sel[`BISM_POS_MBOX0 + 6]  = loc_monitor2_route;
      route_sel[`BISM_POS_MBOX0 + 5]  = loc_monitor1_route;
      route_sel[`BISM_POS_MBOX0 + 4]  = loc_monitor0_route;
      route_sel[`BISM_POS_MBOX0 + 3]  = mailbox3_route;
      route_sel[`BISM_POS_MBOX0 + 2]  = mailbox2_route;
      route_sel[`BISM_POS_MBOX0 + 1]  = mailbox1_route;
      route_sel[`BISM_POS_MBOX0]      = mailbox0_route;
      route_sel[`BISM_POS_ACFAIL + 5] = host_bus_error_route;
      route_sel[`BISM_POS_ACFAIL + 4] = backplane_error_route;
      route_sel[`BISM_POS_ACFAIL + 3] = request_edge_route;
      route_sel[`BISM_POS_ACFAIL + 2] = acknowledge_route;
      route_sel[`BISM_POS_ACFAIL + 1] = system_fail_route;
      route_sel[`BISM_POS_ACFAIL]     = ac_fail_route;
      route_sel[`BISM_POS_LEVEL1 + 6] = request_level7_route;
      route_sel[`BISM_POS_LEVEL1 + 5] = request_level6_route;
      route_sel[`BISM_POS_LEVEL1 + 4] = request_level5_route;
      route_sel[`BISM_POS_LEVEL1 + 3] = request_level4_route;
      route_sel[`BISM_POS_LEVEL1 + 2] = request_level3_route;
      route_sel[`BISM_POS_LEVEL1 + 1] = request_level2_route;
      route_sel[`BISM_POS_LEVEL1]     = request_level1_route;
   end

   // Each enabled pending source drives the line its route field selects.
   always_comb begin
      line_next = 4'h0;
      for (int i = 0; i < 32; i++) begin
         if (pending_reg[i] && output_en_reg[i]) begin
            case (route_sel[i])
               2'b00:   line_next = line_next | BISM_LINE_A;
               2'b01:   line_next = line_next | BISM_LINE_B;
               2'b10:   line_next = line_next | BISM_LINE_C;
               default: line_next = line_next | BISM_LINE_D;
            endcase
         end
      end
   end

   // Registered so the pins never glitch; presetn releases them at once, the soft and local resets at the next clock edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_reg <= 4'h0;
      end else if (local_rst) begin
         line_reg <= 4'h0;
      end else begin
         line_reg <= line_next;
      end
   end

   // Lines are active low.
   assign inta_n = ~line_reg[0];
   assign intb_n = ~line_reg[1];
   assign interrupt_clear_n = ~line_reg[2];
   assign intd_n = ~line_reg[3];
   // The single level interrupt is high while any enabled status bit is set.
   assign irq    = |(pending_reg & irq_enable_reg);

   // The clear register falls to the default branch, so it always reads zero.
   always_comb begin
      case (paddr)
         `BISM_OFF_INPUT_EN:   prdata_next = input_en_reg;
         `BISM_OFF_OUTPUT_EN:  prdata_next = output_en_reg;
         `BISM_OFF_PENDING:    prdata_next = pending_reg;
         `BISM_OFF_ROUTE_ONE:  prdata_next = route_one_reg;
         `BISM_OFF_ROUTE_TWO:  prdata_next = route_two_reg;
         `BISM_OFF_IRQ_ENABLE: prdata_next = irq_enable_reg;
         default:              prdata_next = 32'h00000000;
      endcase
   end

   // Loaded in the setup phase of a read, so prdata stands until the next read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         prdata <= prdata_next;
      end
   end

endmodule

`default_nettype wire

/* src/bism_pkg.sv */
// Types shared by the interrupt status and routing block.
package bism_pkg;
   typedef logic [1:0] bism_route_t;
   typedef enum logic [3:0] {
      BISM_LINE_A = 4'h1,
      BISM_LINE_B = 4'h2,
      BISM_LINE_C = 4'h4,
      BISM_LINE_D = 4'h8
   } bism_line_t;
endpackage
